/* File: rtl/stsc_core.v */
`timescale 1ns/100ps
`include "stsc_consts.vh"

// ----------------------------------------------------------------------------
// Common-command core: status byte, service request, trigger, self test, wait
// ----------------------------------------------------------------------------
module stsc_core #(
  parameter LEVEL_W = 16
) (
  input  wire               MCLK,
  input  wire               RESET_N,
  input  wire               CMD_VALID,
  output wire               CMD_READY,
  input  wire [3:0]         CMD_CODE,
  input  wire [7:0]         CMD_DATA,
  input  wire               LISTEN_ADDRESSED,
  input  wire               GROUP_TRIGGER,
  input  wire               SERIAL_POLL,
  input  wire               OUTPUT_ON,
  input  wire               TRIG_SRC_BUS,
  input  wire               CONTINUOUS_ARM,
  input  wire               OPERATION_SUMMARY,
  input  wire               EVENT_SUMMARY,
  input  wire               MESSAGE_AVAILABLE,
  input  wire               QUESTIONABLE_SUMMARY,
  input  wire               ERROR_QUEUE_NONEMPTY,
  input  wire               LIST_RUNNING,
  input  wire               PRIOR_BUSY,
  input  wire               LEVEL_SETTLED,
  input  wire [LEVEL_W-1:0] PENDING_TRIG_VOLTAGE,
  input  wire [LEVEL_W-1:0] PENDING_TRIG_CURRENT,
  input  wire [7:0]         SUBTEST_FAIL,
  output reg  [LEVEL_W-1:0] OUT_VOLTAGE,
  output reg  [LEVEL_W-1:0] OUT_CURRENT,
  output reg                TRIGGER_PULSE,
  output reg                WAITING_FOR_TRIGGER,
  output reg  [7:0]         RESP_DATA,
  output reg                RESP_VALID,
  output reg  [7:0]         POLL_DATA,
  output reg                POLL_VALID,
  output wire               SERVICE_REQUEST,
  output reg  [7:0]         SERVICE_REQUEST_ENABLE,
  output wire               WAIT_PENDING
);
  localparam ST_IDLE = 2'd0;
  localparam ST_TEST = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg        rst_s1;
  reg        rst_s2;
  reg [7:0]  pin_s1;
  reg [7:0]  pin_s2;
  reg [1:0]  state;
  reg        rqs;
  reg        mss_q;
  wire       rst_n;
  wire       lsn;
  wire       get_s;
  wire       poll_s;
  wire       out_on;
  wire       src_bus;
  wire       cont;
  wire       settled;
  wire       prior_busy;
  wire [7:0] stb_raw;
  wire       mss;
  wire       accept;
  wire       trg_cmd;
  wire       fire;
  wire       st_busy;
  wire       st_done;
  wire [7:0] st_result;

  // ----------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------------
  // Reset enters asynchronously, leaves on clock edges
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  // Bus-side control pins are asynchronous to MCLK
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end else begin
      pin_s1 <= {PRIOR_BUSY, LEVEL_SETTLED, CONTINUOUS_ARM, TRIG_SRC_BUS,
                 OUTPUT_ON, SERIAL_POLL, GROUP_TRIGGER, LISTEN_ADDRESSED};
      pin_s2 <= pin_s1;
    end
  end
  assign lsn        = pin_s2[0];
  assign get_s      = pin_s2[1];
  assign poll_s     = pin_s2[2];
  assign out_on     = pin_s2[3];
  assign src_bus    = pin_s2[4];
  assign cont       = pin_s2[5];
  assign settled    = pin_s2[6];
  assign prior_busy = pin_s2[7];

  // ----------------------------------------------------------------------------
  // Status byte and service request
  // ----------------------------------------------------------------------------
  // Summary sources come from same-clock logic, no sync needed
  assign stb_raw = {OPERATION_SUMMARY, 1'b0, EVENT_SUMMARY, MESSAGE_AVAILABLE,
                    QUESTIONABLE_SUMMARY, ERROR_QUEUE_NONEMPTY, LIST_RUNNING,
                    PRIOR_BUSY};
  // Bit 6 of the mask is always zero, so the self-loop cannot occur
  assign mss = |(stb_raw & SERVICE_REQUEST_ENABLE);
  assign SERVICE_REQUEST = rqs;

  // Request bit: set on rising summary, cleared by poll; set wins
  reg poll_d;
  reg get_d;
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rqs    <= 1'b0;
      mss_q  <= 1'b0;
      poll_d <= 1'b0;
      get_d  <= 1'b0;
    end else begin
      mss_q  <= mss;
      poll_d <= poll_s;
      get_d  <= get_s;
      if (mss && !mss_q)
        rqs <= 1'b1;
      else if (poll_s && !poll_d)
        rqs <= 1'b0;
    end
  end

  // Serial poll answer carries the request bit in position 6
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      POLL_DATA  <= 8'h00;
      POLL_VALID <= 1'b0;
    end else begin
      POLL_VALID <= poll_s && !poll_d;
      if (poll_s && !poll_d)
        POLL_DATA <= {stb_raw[7], rqs, stb_raw[5:0]};
    end
  end

  // ----------------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------------
  // Wait holds every later command; self test holds until its answer
  assign CMD_READY    = (state == ST_IDLE);
  assign WAIT_PENDING = (state == ST_WAIT);
  assign accept       = CMD_VALID && CMD_READY;
  // Group trigger acts on its rising edge only, so a held line fires once
  assign trg_cmd      = (accept && CMD_CODE == `STSC_CMD_TRG) || (get_s && !get_d && state == ST_IDLE);
  // Unarmed or off triggers vanish silently, no error path exists
  assign fire = trg_cmd && lsn && out_on && src_bus && WAITING_FOR_TRIGGER;

  stsc_selftest u_selftest (
    .clk      (MCLK),
    .rst_n    (rst_n),
    .start    (accept && (CMD_CODE == `STSC_CMD_TST_Q || CMD_CODE == `STSC_CMD_DIAG_Q)),
    .extended (CMD_CODE == `STSC_CMD_DIAG_Q),
    .fail_in  (SUBTEST_FAIL),
    .busy     (st_busy),
    .done     (st_done),
    .result   (st_result)
  );

  // Main command process
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state                  <= ST_IDLE;
      SERVICE_REQUEST_ENABLE <= `STSC_SREN_RST;
      RESP_DATA              <= 8'h00;
      RESP_VALID             <= 1'b0;
      WAITING_FOR_TRIGGER    <= 1'b0;
      TRIGGER_PULSE          <= 1'b0;
      OUT_VOLTAGE            <= {LEVEL_W{1'b0}};
      OUT_CURRENT            <= {LEVEL_W{1'b0}};
    end else begin
      RESP_VALID    <= 1'b0;
      TRIGGER_PULSE <= fire;
      if (fire) begin
        OUT_VOLTAGE         <= PENDING_TRIG_VOLTAGE;
        OUT_CURRENT         <= PENDING_TRIG_CURRENT;
        WAITING_FOR_TRIGGER <= cont;
      end else if (cont && !WAITING_FOR_TRIGGER) begin
        WAITING_FOR_TRIGGER <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (accept) begin
            case (CMD_CODE)
              `STSC_CMD_SREN_W:
                SERVICE_REQUEST_ENABLE <= CMD_DATA & `STSC_SREN_WMASK;
              `STSC_CMD_SREN_Q: begin
                RESP_DATA  <= SERVICE_REQUEST_ENABLE;
                RESP_VALID <= 1'b1;
              end
              `STSC_CMD_STB_Q: begin
                RESP_DATA  <= {stb_raw[7], mss, stb_raw[5:0]};
                RESP_VALID <= 1'b1;
              end
              `STSC_CMD_INIT:
                if (!cont)
                  WAITING_FOR_TRIGGER <= 1'b1;
              `STSC_CMD_TST_Q,
              `STSC_CMD_DIAG_Q:
                state <= ST_TEST;
              `STSC_CMD_WAIT:
                state <= ST_WAIT;
              default: ;
            endcase
          end
        end
        ST_TEST: begin
          if (st_done) begin
            RESP_DATA  <= st_result;
            RESP_VALID <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (!prior_busy && settled)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // stsc_core

/* File: rtl/stsc_consts.vh */
// ----------------------------------------------------------------------------
// Contract
// - Enable mask is written as 0 to 255; bit 6 cannot be programmed.
// - Serial poll clears request-for-service; reading master summary leaves it.
// - Status bits gated by mask, ORed, drive status bit 6.
// - Status byte: 7 operation_summary_bit, 6 summary, 5 event, 4 msg, 3 questionable_summary_bit, 2 err, 1 list, 0 busy.
// - Enable mask query returns current mask, 0 to 255.
// - Status byte query returns master summary in bit 6, clears nothing.
// - Serial poll returns request bit in bit 6, then resets it.
// - Bus trigger fires only with bus source and waiting flag set.
// - Arm by continuous arming, or one-shot initiate with continuous off.
// - Trigger while not armed does nothing and reports no error.
// - Trigger applies pending voltage and current, clears waiting flag.
// - Continuous arming rearms at once and sets waiting flag again.
// - Trigger commands act only when addressed as listener.
// - Output off means bus triggers are ignored.
// - Self-test query returns 0 on pass, nonzero bit code on failure.
// - Every subtest runs; each failing subtest sets its own bit.
// - Basic bits: 0 program memory, 1 working memory, 2 flash, 4 analog link.
// - Bits 5, 6, 7 reported only by extended diagnostic test.
// - Wait command holds later commands until earlier ones finish.
// - Wait completes only after commands done and output levels settled.
// ----------------------------------------------------------------------------
`ifndef STSC_CONSTS_VH
`define STSC_CONSTS_VH

// Status byte field positions
`define STSC_BIT_BUSY   3'd0
`define STSC_BIT_LIST   3'd1
`define STSC_BIT_ERRQ   3'd2
`define STSC_BIT_QUESTIONABLE_SUMMARY_BIT   3'd3
`define STSC_BIT_MAV    3'd4
`define STSC_BIT_ESB    3'd5
`define STSC_BIT_MSS    3'd6
`define STSC_BIT_OPERATION_SUMMARY_BIT   3'd7

// Mask and reset values
`define STSC_SREN_WMASK 8'hbf
`define STSC_SREN_RST   8'h00
`define STSC_BASIC_MASK 8'h17
`define STSC_EXT_MASK   8'hf7

// Command codes
`define STSC_CMD_NONE   4'h0
`define STSC_CMD_SREN_W 4'h1
`define STSC_CMD_SREN_Q 4'h2
`define STSC_CMD_STB_Q  4'h3
`define STSC_CMD_TRG    4'h4
`define STSC_CMD_INIT   4'h5
`define STSC_CMD_TST_Q  4'h6
`define STSC_CMD_DIAG_Q 4'h7
`define STSC_CMD_WAIT   4'h8

// Self-test timing: time per subtest and clock period, in ns
`define STSC_SUBTEST_NS 100
`define STSC_CLK_NS     4

`endif

/* File: rtl/stsc_selftest.v */
`timescale 1ns/100ps
`include "stsc_consts.vh"

// ----------------------------------------------------------------------------
// Self-test sequencer: walks all subtests, gathers a failure bit per subtest
// ----------------------------------------------------------------------------
module stsc_selftest #(
  parameter SUBTEST_CYC = (`STSC_SUBTEST_NS + `STSC_CLK_NS - 1) / `STSC_CLK_NS
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire       extended,
  input  wire [7:0] fail_in,
  output reg        busy,
  output reg        done,
  output reg  [7:0] result
);
  reg [2:0]  idx;
  reg [15:0] cnt;
  reg        ext;

  localparam [7:0] BASIC_M = `STSC_BASIC_MASK;
  localparam [7:0] EXT_M   = `STSC_EXT_MASK;

  // One bit position per subtest; unused positions are skipped quickly
  function sel_bit;
    input [2:0] i;
    input       e;
    begin
      sel_bit = e ? EXT_M[i] : BASIC_M[i];
    end
  endfunction

  // Sequencer keeps going after a failure, only accumulating bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= 8'h00;
      idx    <= 3'd0;
      cnt    <= 16'h0000;
      ext    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy   <= 1'b1;
        ext    <= extended;
        result <= 8'h00;
        idx    <= 3'd0;
        cnt    <= 16'h0000;
      end else if (busy) begin
        if (!sel_bit(idx, ext) || cnt == SUBTEST_CYC[15:0] - 16'h0001) begin
          if (sel_bit(idx, ext) && fail_in[idx])
            result[idx] <= 1'b1;
          cnt <= 16'h0000;
          idx <= idx + 3'd1;
          if (idx == 3'd7) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end
endmodule // stsc_selftest

/* File: tb/stsc_core_monitor.sv */
`timescale 1ns/100ps
// Pin-level checks on the command core
module stsc_core_monitor #(parameter LEVEL_W = 16) (
  input logic               MCLK,
  input logic               RESET_N,
  input logic               CMD_VALID,
  input logic               CMD_READY,
  input logic [3:0]         CMD_CODE,
  input logic [7:0]         CMD_DATA,
  input logic               GROUP_TRIGGER,
  input logic               PRIOR_BUSY,
  input logic [LEVEL_W-1:0] PENDING_TRIG_VOLTAGE,
  input logic [LEVEL_W-1:0] PENDING_TRIG_CURRENT,
  input logic [LEVEL_W-1:0] OUT_VOLTAGE,
  input logic [LEVEL_W-1:0] OUT_CURRENT,
  input logic               TRIGGER_PULSE,
  input logic               WAITING_FOR_TRIGGER,
  input logic [7:0]         RESP_DATA,
  input logic               RESP_VALID,
  input logic [7:0]         POLL_DATA,
  input logic               POLL_VALID,
  input logic               SERVICE_REQUEST,
  input logic [7:0]         SERVICE_REQUEST_ENABLE,
  input logic               WAIT_PENDING
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  wire      take = CMD_VALID && CMD_READY;
  reg [3:0] last_code;
  // Which command an answer belongs to; test holds off new commands
  always @(posedge MCLK or negedge RESET_N)
    if (!RESET_N) last_code <= 4'h0;
    else if (take) last_code <= CMD_CODE;
  sequence mask_write; take && CMD_CODE == 4'h1; endsequence
  sequence busy_held; PRIOR_BUSY [*4]; endsequence
  mask_write_a: assert property (
    mask_write |=> SERVICE_REQUEST_ENABLE == ($past(CMD_DATA) & 8'hbf))
    else $error("mask write not stored");
  status_sum_a: assert property (
    RESP_VALID && last_code == 4'h3 |-> RESP_DATA[6] == |(RESP_DATA & SERVICE_REQUEST_ENABLE & 8'hbf))
    else $error("summary bit wrong");
  poll_rqs_a: assert property (
    POLL_VALID |-> POLL_DATA[6] == $past(SERVICE_REQUEST))
    else $error("poll request bit wrong");
  trig_cause_a: assert property (
    TRIGGER_PULSE |-> $past(WAITING_FOR_TRIGGER) && ($past(take && CMD_CODE == 4'h4) || $past(GROUP_TRIGGER, 3)))
    else $error("trigger without cause");
  trig_load_a: assert property (
    TRIGGER_PULSE |-> OUT_VOLTAGE == $past(PENDING_TRIG_VOLTAGE) && OUT_CURRENT == $past(PENDING_TRIG_CURRENT))
    else $error("trigger levels wrong");
  test_bits_a: assert property (
    RESP_VALID && last_code == 4'h6 |-> (RESP_DATA & 8'he8) == 8'h00)
    else $error("basic test shows extended bits");
  wait_hold_a: assert property (
    WAIT_PENDING |-> !CMD_READY)
    else $error("command taken during wait");
  wait_busy_a: assert property (
    busy_held ##0 WAIT_PENDING |=> WAIT_PENDING)
    else $error("wait ended while busy");
endmodule // stsc_core_monitor
bind stsc_core stsc_core_monitor #(.LEVEL_W(LEVEL_W)) stsc_core_monitor_inst (.*);

/* File: tb/stsc_ctrl_model.sv */
`timescale 1ns/100ps
// Bus controller: offers commands, addresses, polls
module stsc_ctrl_model (
  input  logic       clk,
  input  logic       ready,
  input  logic       poll_valid,
  input  logic [7:0] poll_data,
  output logic       valid = 1'b0,
  output logic [3:0] code = 4'h0,
  output logic [7:0] data = 8'h00,
  output logic       listen = 1'b1,
  output logic       poll = 1'b0
);
  // Offer held until taken; a byte is always 0..255
  task automatic send(input logic [3:0] c, input logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clk);
    valid <= 1'b1;
    code <= c;
    data <= d;
    for (int i = 0; i < 600 && !ok; i++) begin
      @(negedge clk);
      ok = ready;
    end
    @(posedge clk);
    valid <= 1'b0;
    code <= ~c; // Released bus shows junk, not the old value
    data <= ~d;
  endtask
  // Raise poll, catch the byte, drop
  task automatic serial_poll(output logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clk);
    poll <= 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk);
      ok = poll_valid;
      d = poll_data;
    end
    @(posedge clk);
    poll <= 1'b0;
  endtask
  // Listener addressing
  task automatic address(input logic v);
    @(posedge clk);
    listen <= v;
  endtask
endmodule // stsc_ctrl_model

/* File: tb/status_trigger_selftest_core_tb_top.sv */
`timescale 1ns/100ps
module status_trigger_selftest_core_tb_top;
  logic        mclk = 0, reset_n = 0, out_on = 0, src_bus = 0, cont = 0, settled = 1;
  logic [7:0]  src = 0, fail = 0;
  logic        get = 0;
  logic [15:0] pv = 0, pc = 0;
  wire         valid, ready, listen, poll, pulse, waiting, rv, pvld, srq, wpend;
  wire [3:0]   code;
  wire [7:0]   data, rd, pd, service_request_enable_mask;
  wire [15:0]  ov, oc;
  int          num_errors = 0, cmp_count = 0;
  always #2 mclk = ~mclk;
  stsc_ctrl_model stsc_ctrl_model_inst (.clk(mclk), .ready(ready), .poll_valid(pvld), .poll_data(pd),
    .valid(valid), .code(code), .data(data), .listen(listen), .poll(poll));
  stsc_core stsc_core_inst (.MCLK(mclk), .RESET_N(reset_n), .CMD_VALID(valid), .CMD_READY(ready),
    .CMD_CODE(code), .CMD_DATA(data), .LISTEN_ADDRESSED(listen), .GROUP_TRIGGER(get), .SERIAL_POLL(poll),
    .OUTPUT_ON(out_on), .TRIG_SRC_BUS(src_bus), .CONTINUOUS_ARM(cont), .OPERATION_SUMMARY(src[7]),
    .EVENT_SUMMARY(src[5]), .MESSAGE_AVAILABLE(src[4]), .QUESTIONABLE_SUMMARY(src[3]),
    .ERROR_QUEUE_NONEMPTY(src[2]), .LIST_RUNNING(src[1]), .PRIOR_BUSY(src[0]), .LEVEL_SETTLED(settled),
    .PENDING_TRIG_VOLTAGE(pv), .PENDING_TRIG_CURRENT(pc), .SUBTEST_FAIL(fail), .OUT_VOLTAGE(ov),
    .OUT_CURRENT(oc), .TRIGGER_PULSE(pulse), .WAITING_FOR_TRIGGER(waiting), .RESP_DATA(rd), .RESP_VALID(rv),
    .POLL_DATA(pd), .POLL_VALID(pvld), .SERVICE_REQUEST(srq), .SERVICE_REQUEST_ENABLE(service_request_enable_mask), .WAIT_PENDING(wpend));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    chk("wait", 1, 0);
    test_done();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] d);
    bit ok;
    stsc_ctrl_model_inst.send(c, d, ok);
    if (!ok) hang();
  endtask
  // Answers stand one cycle: caught at the falling edge
  task automatic query(input logic [3:0] c, output logic [7:0] r);
    bit ok;
    cmd(c, 8'h00);
    for (int i = 0; i < 600 && !ok; i++) begin
      @(negedge mclk);
      ok = rv;
      r = rd;
    end
    if (!ok) hang();
  endtask
  task automatic spoll(input logic [7:0] e, input string nm);
    logic [7:0] r;
    bit ok;
    stsc_ctrl_model_inst.serial_poll(r, ok);
    if (!ok) hang();
    chk(nm, e, r);
    chk("rqs cleared", 0, srq);
  endtask
  task automatic trg(input int e, input string nm);
    int n;
    cmd(4'h4, 8'h00);
    n = 0;
    repeat (3) begin
      @(negedge mclk);
      n += pulse;
    end
    chk(nm, e, n);
  endtask
  task automatic t_mask();
    logic [7:0] r;
    cmd(4'h1, 8'hff);
    query(4'h2, r);
    chk("mask bit6", 8'hbf, r);
    cmd(4'h1, 8'h28);
    query(4'h2, r);
    chk("mask", 8'h28, r);
    chk("mask reg", 8'h28, service_request_enable_mask);
  endtask
  task automatic t_status();
    logic [7:0] r;
    cmd(4'h1, 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      src <= 8'h01 << k;
      tick(4);
      query(4'h3, r);
      chk("status bit", (k == 6) ? 8'h00 : 8'h01 << k, r);
    end
    @(posedge mclk);
    src <= 8'h20;
    cmd(4'h1, 8'h28);
    tick(4);
    query(4'h3, r);
    chk("summary", 8'h60, r);
    query(4'h3, r);
    chk("summary kept", 8'h60, r);
    @(posedge mclk);
    src <= 8'h00;
    tick(4);
    query(4'h3, r);
    chk("sources gone", 8'h00, r);
  endtask
  task automatic t_poll();
    logic [7:0] r;
    spoll(8'h40, "poll rqs");
    spoll(8'h00, "poll again");
    @(posedge mclk);
    src <= 8'h08;
    tick(6);
    chk("rqs set", 1, srq);
    spoll(8'h48, "poll questionable_summary_bit");
    query(4'h3, r);
    chk("mss stays", 8'h48, r);
  endtask
  task automatic t_trig();
    int n;
    @(posedge mclk);
    out_on <= 1;
    src_bus <= 1;
    pv <= 16'h1234;
    pc <= 16'h0567;
    tick(4);
    trg(0, "unarmed");
    cmd(4'h5, 8'h00);
    tick(2);
    @(negedge mclk);
    chk("armed", 1, waiting);
    stsc_ctrl_model_inst.address(1'b0);
    tick(4);
    trg(0, "unaddressed");
    stsc_ctrl_model_inst.address(1'b1);
    out_on <= 0;
    tick(4);
    trg(0, "output off");
    @(posedge mclk);
    out_on <= 1;
    src_bus <= 0;
    tick(4);
    trg(0, "not bus");
    @(posedge mclk);
    src_bus <= 1;
    tick(4);
    trg(1, "fire");
    chk("levels", 32'h12340567, {ov, oc});
    chk("one shot", 0, waiting);
    trg(0, "spent");
    @(posedge mclk);
    cont <= 1;
    pv <= 16'habcd;
    tick(4);
    trg(1, "continuous");
    tick(3);
    @(negedge mclk);
    chk("rearm", 17'h1abcd, {waiting, ov});
    // Held group trigger must fire once, even with continuous arming
    @(posedge mclk);
    get <= 1;
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      n += pulse;
    end
    chk("group trigger", 1, n);
    @(posedge mclk);
    get <= 0;
  endtask
  task automatic t_test();
    logic [7:0] f [3] = '{8'hff, 8'h00, 8'h05};
    logic [7:0] r;
    foreach (f[i]) begin
      @(posedge mclk);
      fail <= f[i];
      query(4'h6, r);
      chk("self test", f[i] & 8'h17, r);
      query(4'h7, r);
      chk("diag", f[i] & 8'hf7, r);
    end
  endtask
  task automatic t_wait();
    logic [7:0] r;
    @(posedge mclk);
    src <= 8'h01;
    settled <= 0;
    cmd(4'h8, 8'h00);
    tick(10);
    @(negedge mclk);
    chk("held busy", 2'b10, {wpend, ready});
    @(posedge mclk);
    src <= 8'h00;
    tick(10);
    @(negedge mclk);
    chk("held unsettled", 2'b10, {wpend, ready});
    @(posedge mclk);
    settled <= 1;
    query(4'h2, r);
    chk("after wait", 8'h28, r);
  endtask
  initial begin
    tick(5);
    reset_n <= 1;
    tick(6);
    t_mask();
    t_status();
    t_poll();
    t_trig();
    t_test();
    t_wait();
    test_done();
  end
endmodule // status_trigger_selftest_core_tb_top
